// *** verilog/spi_pkg.sv ***
/*
 Constants of the byte-wide SPI port: register indices, field positions,
 reset values, divider settings and the transfer state type.
 Assumes a register index is a 32-bit word on an Avalon-MM bus.
*/
// Summary of operation
// - Port keeps running normally in idle sleep.
// - Any deeper sleep aborts a transfer in progress.
// - Bit order 0 sends MSB first, 1 sends LSB first.
// - Role bit 0 selects slave, 1 selects master.
// - Master with select input low drops to slave and raises combined flag, or select flag when buffered.
// - With select disable set, select input never drops master role.
// - Divider codes 0 to 3 give serial clock of peripheral clock /4, /16, /64, /128.
// - Divider setting has no effect in slave role.
// - Clock double bit doubles master serial clock after divider.
// - Buffered mode adds two receive buffers, one transmit buffer, separate flags.
// - Buffered without wait: dummy byte first, data reaches shifter after a transfer.
// - Buffered with wait: first write while enabled and select high loads shifter.
// - Modes 0 and 2 sample leading edge, modes 1 and 3 trailing edge.
// - Modes 0 and 1 idle low and lead rising; 2 and 3 idle high.
// - Buffered: receive enable lets receive flag raise the interrupt.
// - Buffered: transfer, empty and select enables gate their flags.
// - Unbuffered: the four buffered enables read as zero.
// - Unbuffered: single enable lets combined flag raise the interrupt.
// - Interrupt holds while any enabled flag stays set.
// - Unbuffered write during a transfer is dropped and sets collision flag.
// - Unbuffered: combined flag set after each whole byte.
// - Writing data in master role starts a transfer shifting that byte out, except buffered without wait.
package spi_pkg;
   // ----------------------------------------
   // Register indices and masks
   // ----------------------------------------
   localparam logic [2:0] IDX_CONTROL_A = 3'h0;
   localparam logic [2:0] IDX_CONTROL_B = 3'h1;
   localparam logic [2:0] IDX_INT_EN = 3'h2;
   localparam logic [2:0] IDX_INT_FLAGS = 3'h3;
   localparam logic [2:0] IDX_SHIFT_DATA = 3'h4;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [7:0] CONTROL_A_MASK = 8'h77;
   localparam logic [7:0] CONTROL_B_MASK = 8'hc7;
   localparam logic [7:0] INT_EN_MASK = 8'hf1;
   localparam logic [7:0] INT_EN_PLAIN_MASK = 8'h01;
   localparam logic [23:0] READ_PAD = 24'h000000;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_ORDER = 6;
   localparam int BIT_MASTER = 5;
   localparam int BIT_CLOCK_DOUBLE = 4;
   localparam int DIV_SEL_HI = 2;
   localparam int DIV_SEL_LO = 1;
   localparam int BIT_ENABLE = 0;
   localparam int BIT_BUFFERED = 7;
   localparam int BIT_WAIT_RX = 6;
   localparam int BIT_SELECT_DISABLE = 2;
   localparam int BIT_CPOL = 1;
   localparam int BIT_CPHA = 0;
   localparam int FLG_RX_DONE = 7;
   localparam int FLG_TX_DONE = 6;
   localparam int FLG_TX_EMPTY = 5;
   localparam int FLG_SELECT = 4;
   localparam int FLG_OVERFLOW = 0;
   localparam int EN_SINGLE = 0;
   // ----------------------------------------
   // Divider and transfer
   // ----------------------------------------
   localparam int HALF_W = 7;
   localparam logic [1:0] SEL_DIV4 = 2'h0;
   localparam logic [1:0] SEL_DIV16 = 2'h1;
   localparam logic [1:0] SEL_DIV64 = 2'h2;
   localparam logic [6:0] HALF_DIV4 = 7'h02;
   localparam logic [6:0] HALF_DIV16 = 7'h08;
   localparam logic [6:0] HALF_DIV64 = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [1:0] RX_NONE = 2'h0;
   localparam logic [1:0] RX_ONE = 2'h1;
   localparam logic [1:0] RX_FULL = 2'h2;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SHIFT = 2'b01, ST_DONE = 2'b11} xfer_state_t;
endpackage

// *** verilog/spi_clk_div.sv ***
/*
 Half-period strobe for the master serial clock.
 Assumes i_run stays high for the whole transfer; dropping it restarts the count.
*/
`timescale 1ns/1ps
module spi_clk_div #(
   parameter int HALF_W = 7
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Control
   input wire logic i_run,
   input wire logic [HALF_W-1:0] i_half,
   // Strobe
   output logic o_tick
);
   logic [HALF_W-1:0] cnt_q;
   wire cnt_end = (cnt_q == i_half - 1'b1);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || !i_run)
      begin
         cnt_q <= {HALF_W{1'b0}};
         o_tick <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_end ? {HALF_W{1'b0}} : cnt_q + 1'b1;
         o_tick <= cnt_end;
      end
   end
endmodule

// *** verilog/spi_shifter.sv ***
/*
 Eight-bit shift register shared by transmit and receive.
 Assumes load and shift never arrive in the same cycle; load wins if they do.
*/
`timescale 1ns/1ps
module spi_shifter #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Control
   input wire logic i_load,
   input wire logic [W-1:0] i_load_data,
   input wire logic i_shift,
   input wire logic i_in_bit,
   input wire logic i_lsb_first,
   // State
   output logic [W-1:0] o_data,
   output logic o_out_bit
);
   assign o_out_bit = i_lsb_first ? o_data[0] : o_data[W-1];

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_data <= {W{1'b0}};
      else if (i_load)
         o_data <= i_load_data;
      else if (i_shift)
         o_data <= i_lsb_first ? {i_in_bit, o_data[W-1:1]} : {o_data[W-2:0], i_in_bit};
   end

   a_bit_order:
   assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_shift && !i_load |=> (i_lsb_first ? o_data[W-1] : o_data[0]) == $past(i_in_bit))
      else $error("Received bit landed at the wrong end");
endmodule

// *** verilog/spi_master_slave_port.sv ***
/*
 Byte-wide SPI port, master or slave, with its register bank on Avalon-MM.
 Assumes serial pin inputs are already synchronous to i_ref_clk and that the
 pad logic resolves each line from the output enables.
*/
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module spi_master_slave_port (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Avalon-MM slave
   input wire logic [2:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Power state
   input wire logic i_deep_sleep,
   // Slave select
   input wire logic i_ss_is_input,
   input wire logic i_ss_n,
   // Serial clock
   input wire logic i_sck,
   output logic o_sck,
   output logic o_sck_oe,
   // Serial data
   input wire logic i_mosi,
   output logic o_mosi,
   output logic o_mosi_oe,
   input wire logic i_miso,
   output logic o_miso,
   output logic o_miso_oe,
   // Interrupt
   output logic o_irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] ctrl_a_q, ctrl_b_q, ie_q;
   logic f_rx_q, f_tx_q, f_dre_q, f_ss_q, f_ovf_q, armed_q;
   logic [7:0] txb_q, rx_new_q, rx_old_q;
   logic txb_v_q, pend_q, wait_q, sck_q, sck_prev_q, out_q;
   logic master_oe_q, miso_oe_q, irq_q;
   logic [1:0] rx_cnt_q;
   logic [3:0] edge_cnt_q;
   logic [31:0] rdata_q;
   logic tick, sh_out;
   logic [7:0] sh_data;
   spi_pkg::xfer_state_t state_q, state_d;

   // ----------------------------------------
   // Configuration fields
   // ----------------------------------------
   wire en = ctrl_a_q[spi_pkg::BIT_ENABLE];
   wire master = ctrl_a_q[spi_pkg::BIT_MASTER];
   wire lsb_first = ctrl_a_q[spi_pkg::BIT_ORDER];
   wire dbl = ctrl_a_q[spi_pkg::BIT_CLOCK_DOUBLE];
   wire [1:0] div_sel = ctrl_a_q[spi_pkg::DIV_SEL_HI:spi_pkg::DIV_SEL_LO];
   wire buffered = ctrl_b_q[spi_pkg::BIT_BUFFERED];
   wire wait_rx = ctrl_b_q[spi_pkg::BIT_WAIT_RX];
   wire select_disable = ctrl_b_q[spi_pkg::BIT_SELECT_DISABLE];
   wire cpol = ctrl_b_q[spi_pkg::BIT_CPOL];
   wire cpha = ctrl_b_q[spi_pkg::BIT_CPHA];

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire req = i_avs_read | i_avs_write;
   wire rd = i_avs_read & ~wait_q;
   wire wr = i_avs_write & ~wait_q;
   wire [7:0] wdata = i_avs_writedata[7:0];
   wire sel_ca = i_avs_address == spi_pkg::IDX_CONTROL_A;
   wire sel_cb = i_avs_address == spi_pkg::IDX_CONTROL_B;
   wire sel_ie = i_avs_address == spi_pkg::IDX_INT_EN;
   wire sel_fl = i_avs_address == spi_pkg::IDX_INT_FLAGS;
   wire sel_dt = i_avs_address == spi_pkg::IDX_SHIFT_DATA;
   wire wr_ca = wr & sel_ca;
   wire wr_cb = wr & sel_cb;
   wire wr_ie = wr & sel_ie;
   wire wr_fl = wr & sel_fl;
   wire wr_data = wr & sel_dt;
   wire rd_data = rd & sel_dt;
   wire rd_flags = rd & sel_fl;
   wire acc_data = (rd | wr) & sel_dt;
   // Buffered-only fields are hidden outside buffered mode
   wire [7:0] ie_view = buffered ? ie_q : (ie_q & spi_pkg::INT_EN_PLAIN_MASK);
   wire [7:0] fl_view = buffered ? {f_rx_q, f_tx_q, f_dre_q, f_ss_q, 3'h0, f_ovf_q} : {f_rx_q, f_tx_q, 6'h00};
   wire [7:0] rd_mux = sel_ca ? ctrl_a_q :
                       sel_cb ? ctrl_b_q :
                       sel_ie ? ie_view :
                       sel_fl ? fl_view :
                       sel_dt ? rx_old_q : spi_pkg::RESET_VALUE;

   // ----------------------------------------
   // Serial edges
   // ----------------------------------------
   wire idle = state_q == spi_pkg::ST_IDLE;
   wire shifting = state_q == spi_pkg::ST_SHIFT;
   wire done = state_q == spi_pkg::ST_DONE;
   wire ss_fault = en & master & i_ss_is_input & ~select_disable & ~i_ss_n;
   // Of the power states only a deeper sleep stops a transfer; idle sleep leaves the port running
   wire abort = i_deep_sleep | ~en | ss_fault | (~master & i_ss_n);
   wire slave_edge = ~master & (i_sck != sck_prev_q);
   wire any_edge = master ? tick : slave_edge;
   wire lead_edge = any_edge & ((master ? sck_q : sck_prev_q) == cpol);
   wire trail_edge = any_edge & ~lead_edge;
   wire sample_edge = shifting & (cpha ? trail_edge : lead_edge);
   wire setup_edge = shifting & (cpha ? lead_edge : trail_edge);
   wire last_edge = shifting & any_edge & (edge_cnt_q == spi_pkg::LAST_EDGE);
   wire [6:0] half_base = (div_sel == spi_pkg::SEL_DIV4) ? spi_pkg::HALF_DIV4 :
                          (div_sel == spi_pkg::SEL_DIV16) ? spi_pkg::HALF_DIV16 :
                          (div_sel == spi_pkg::SEL_DIV64) ? spi_pkg::HALF_DIV64 : spi_pkg::HALF_DIV128;
   wire [6:0] half = dbl ? (half_base >> 1) : half_base;

   // ----------------------------------------
   // Data path control
   // ----------------------------------------
   wire start_master = idle & en & master & ~ss_fault & ~i_deep_sleep &
                       (pend_q | (buffered & ~wait_rx & txb_v_q));
   wire start_slave = idle & en & ~master & ~i_ss_n & ~i_deep_sleep;
   wire direct_wr = buffered & wait_rx & en & i_ss_n & idle & ~pend_q & ~txb_v_q;
   wire load_wr = wr_data & (buffered ? direct_wr : idle);
   wire collide = wr_data & ~buffered & ~idle;
   wire buf_wr = wr_data & buffered & ~direct_wr & ~txb_v_q;
   wire copy_txb = done & buffered & txb_v_q;
   wire pop = rd_data & buffered & (rx_cnt_q != spi_pkg::RX_NONE);
   wire [1:0] rx_left = rx_cnt_q - {1'b0, pop};
   wire rx_store = done & buffered;
   wire overflow = rx_store & (rx_left == spi_pkg::RX_FULL);
   wire [3:0] fl_hi = {f_rx_q, f_tx_q, f_dre_q, f_ss_q};
   wire irq_cond = buffered ? |(fl_hi & ie_q[7:4]) : (f_rx_q & ie_q[spi_pkg::EN_SINGLE]);

   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_sck = sck_q;
   assign o_sck_oe = master_oe_q;
   assign o_mosi = out_q;
   assign o_mosi_oe = master_oe_q;
   assign o_miso = out_q;
   assign o_miso_oe = miso_oe_q;
   assign o_irq = irq_q;

   // ----------------------------------------
   // Leaf instances
   // ----------------------------------------
   // Divider runs only in master role, so its setting is inert in slave role
   spi_clk_div #(
      .HALF_W(spi_pkg::HALF_W)
   ) u_div (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_run(shifting & master),
      .i_half(half),
      .o_tick(tick)
   );

   spi_shifter #(
      .W(8)
   ) u_shift (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(load_wr | copy_txb),
      .i_load_data(copy_txb ? txb_q : wdata),
      .i_shift(sample_edge),
      .i_in_bit(master ? i_miso : i_mosi),
      .i_lsb_first(lsb_first),
      .o_data(sh_data),
      .o_out_bit(sh_out)
   );

   // ----------------------------------------
   // Transfer sequencer
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         spi_pkg::ST_IDLE:
            if (start_master || start_slave)
               state_d = spi_pkg::ST_SHIFT;
         spi_pkg::ST_SHIFT:
            if (abort)
               state_d = spi_pkg::ST_IDLE;
            else if (last_edge)
               state_d = spi_pkg::ST_DONE;
         spi_pkg::ST_DONE:
            state_d = spi_pkg::ST_IDLE;
         default:
            state_d = spi_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         state_q <= spi_pkg::ST_IDLE;
         edge_cnt_q <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         edge_cnt_q <= !shifting ? 4'h0 : edge_cnt_q + {3'h0, any_edge};
      end
   end

   // ----------------------------------------
   // Serial pins
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         sck_q <= 1'b0;
         sck_prev_q <= 1'b0;
         out_q <= 1'b0;
         master_oe_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end
      else
      begin
         sck_prev_q <= i_sck;
         sck_q <= !(shifting & master) ? cpol : (tick ? ~sck_q : sck_q);
         out_q <= (idle | setup_edge) ? sh_out : out_q;
         master_oe_q <= en & master;
         miso_oe_q <= en & ~master & ~i_ss_n;
      end
   end

   // ----------------------------------------
   // Bus slave: one wait cycle, then the access completes
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         wait_q <= ~(req & wait_q);
         if (req & wait_q)
            rdata_q <= {spi_pkg::READ_PAD, rd_mux};
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         ctrl_a_q <= spi_pkg::RESET_VALUE;
         ctrl_b_q <= spi_pkg::RESET_VALUE;
         ie_q <= spi_pkg::RESET_VALUE;
      end
      else
      begin
         if (wr_ca)
            ctrl_a_q <= wdata & spi_pkg::CONTROL_A_MASK;
         // A select fault outranks a software write in the same cycle
         if (ss_fault)
            ctrl_a_q[spi_pkg::BIT_MASTER] <= 1'b0;
         if (wr_cb)
            ctrl_b_q <= wdata & spi_pkg::CONTROL_B_MASK;
         if (wr_ie)
            ie_q <= wdata & spi_pkg::INT_EN_MASK;
      end
   end

   // ----------------------------------------
   // Flags: clears first, sets after, so a same-cycle event is kept
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         {f_rx_q, f_tx_q, f_dre_q, f_ss_q, f_ovf_q, armed_q} <= 6'h00;
      end
      else
      begin
         if (wr_fl & buffered & wdata[spi_pkg::FLG_RX_DONE])
            f_rx_q <= 1'b0;
         if (wr_fl & buffered & wdata[spi_pkg::FLG_TX_DONE])
            f_tx_q <= 1'b0;
         if (wr_fl & buffered & wdata[spi_pkg::FLG_SELECT])
            f_ss_q <= 1'b0;
         if (acc_data & armed_q)
            {f_rx_q, f_tx_q} <= 2'h0;
         if (pop & (rx_left == spi_pkg::RX_NONE))
            f_rx_q <= 1'b0;
         if (rd_data)
            f_ovf_q <= 1'b0;
         if (buf_wr)
            f_dre_q <= 1'b0;
         if ((done & ~buffered) | rx_store | (ss_fault & ~buffered))
            f_rx_q <= 1'b1;
         if (ss_fault & buffered)
            f_ss_q <= 1'b1;
         if (collide | (done & buffered & ~txb_v_q))
            f_tx_q <= 1'b1;
         if (copy_txb)
            f_dre_q <= 1'b1;
         if (overflow)
            f_ovf_q <= 1'b1;
         if (rd_flags & ~buffered & (f_rx_q | f_tx_q))
            armed_q <= 1'b1;
         else if (acc_data)
            armed_q <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         irq_q <= 1'b0;
      else
         irq_q <= irq_cond;
   end

   // ----------------------------------------
   // Transmit and receive buffers
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         txb_q <= 8'h00;
         txb_v_q <= 1'b0;
         pend_q <= 1'b0;
      end
      else
      begin
         if (buf_wr)
            txb_q <= wdata;
         if (buf_wr | copy_txb)
            txb_v_q <= buf_wr;
         if (load_wr | copy_txb)
            pend_q <= 1'b1;
         else if (shifting)
            pend_q <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         rx_new_q <= 8'h00;
         rx_old_q <= 8'h00;
         rx_cnt_q <= spi_pkg::RX_NONE;
      end
      else
      begin
         if (pop)
            rx_old_q <= rx_new_q;
         if ((done & ~buffered) | (rx_store & (rx_left == spi_pkg::RX_NONE)))
            rx_old_q <= sh_data;
         if (rx_store & (rx_left == spi_pkg::RX_ONE))
            rx_new_q <= sh_data;
         rx_cnt_q <= (rx_store & ~overflow) ? rx_left + 2'h1 : rx_left;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_fault_seen;
      ss_fault;
   endsequence
   sequence s_role_cleared;
      !master && (f_rx_q || f_ss_q);
   endsequence

   a_deep_abort:
   assert property (i_deep_sleep && !idle |=> idle)
      else $error("Transfer kept running in deep sleep");
   a_role_lost:
   assert property (s_fault_seen |=> s_role_cleared)
      else $error("Select fault did not drop master role");
   a_select_kept:
   assert property (en && master && select_disable && !wr_ca |=> master)
      else $error("Master role lost with select disabled");
   a_write_collision:
   assert property (collide |=> f_tx_q && !pend_q)
      else $error("Collision not flagged");
   a_byte_length:
   assert property (done |-> $past(edge_cnt_q) == spi_pkg::LAST_EDGE)
      else $error("Byte did not take sixteen clock edges");
   a_plain_irq:
   assert property (!buffered && f_rx_q && ie_q[spi_pkg::EN_SINGLE] ##1 !buffered |-> o_irq)
      else $error("Unbuffered interrupt missing");
   a_empty_irq:
   assert property (buffered && f_dre_q && ie_q[spi_pkg::FLG_TX_EMPTY] |=> o_irq)
      else $error("Buffered interrupt missing");
   a_enables_hidden:
   assert property (req && wait_q && sel_ie && !buffered |=> o_avs_readdata[7:1] == 7'h00)
      else $error("Buffered enables visible outside buffered mode");
   a_clock_idle:
   assert property ((idle && $stable(ctrl_b_q)) [*2] |-> o_sck == cpol)
      else $error("Serial clock not at idle level");
   a_disabled_quiet:
   assert property (!en |=> !o_sck_oe && !o_miso_oe && idle)
      else $error("Disabled port touched the pins");
   a_buffer_copy:
   assert property (copy_txb |=> f_dre_q && pend_q && !txb_v_q)
      else $error("Transmit buffer not moved to shifter");
   a_direct_load:
   assert property (wr_data && direct_wr |=> pend_q && !txb_v_q)
      else $error("First write did not reach shifter");
   a_slave_no_div:
   assert property (!master && $past(master) == 1'b0 |-> !tick)
      else $error("Divider ran in slave role");
endmodule

// *** dv/spi_peer_model.sv ***
/*
 Behavioural SPI slave peer, mode 0, MSB first.
 Assumes it is selected only while the port drives the serial clock.
*/
`timescale 1ns/1ps
module spi_peer_model (
   // Serial side
   input wire logic i_sck,
   input wire logic i_sel_n,
   input wire logic i_mosi,
   output logic o_miso,
   // Bench side
   input wire logic [7:0] i_reply,
   output logic [7:0] o_got
);
   logic [7:0] tx_q = 8'h00;
   int n = 0;
   // Released line shows the inverse, so a stale bit never passes
   assign o_miso = i_sel_n ? ~tx_q[7] : tx_q[7];
   always @(negedge i_sel_n)
   begin
      tx_q = i_reply;
      n = 0;
   end
   always @(posedge i_sck)
   begin
      if (!i_sel_n)
      begin
         o_got = {o_got[6:0], i_mosi};
         n++;
      end
   end
   always @(negedge i_sck)
   begin
      if (!i_sel_n)
         tx_q = (n == 8) ? i_reply : tx_q << 1;
      if (n == 8)
         n = 0;
   end
endmodule

// *** dv/tb_top.sv ***
/*
 Register-level bench for the SPI port in master role.
 Assumes one wait state per access and a mode 0 peer.
*/
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic ss_in = 1'b0;
   logic ss_n = 1'b1;
   logic sleep = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wreq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, irq;
   logic [7:0] q;
   logic [7:0] got;
   int num_errors = 0;
   int checks_done = 0;
   int n;
   int div [4] = '{4, 16, 64, 128};
   spi_master_slave_port spi_master_slave_port_inst (.i_ref_clk(clk), .i_sys_rst(rst),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_deep_sleep(sleep),
      .i_ss_is_input(ss_in), .i_ss_n(ss_n), .i_sck(1'b0), .o_sck(sck), .o_sck_oe(sck_oe),
      .i_mosi(1'b0), .o_mosi(mosi), .o_mosi_oe(mosi_oe), .i_miso(miso), .o_miso(),
      .o_miso_oe(miso_oe), .o_irq(irq));
   spi_peer_model spi_peer_model_inst (.i_sck(sck), .i_sel_n(!sck_oe), .i_mosi(mosi),
      .o_miso(miso), .i_reply(8'h3c), .o_got(got));
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task bus(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= {24'h000000, d};
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task rchk(input logic [2:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   // Polls flags; the flag read also arms the clear by the next data access
   task wait_done;
      repeat (400)
      begin
         bus(1'b0, spi_pkg::IDX_INT_FLAGS, 8'h00);
         if (q[7] === 1'b1)
            break;
      end
   endtask
   task period(output int c);
      int r;
      logic p;
      r = 0;
      c = 0;
      p = sck;
      repeat (3000)
      begin
         @(posedge clk);
         if (r == 1)
            c++;
         if (sck === 1'b1 && p === 1'b0)
            r++;
         p = sck;
         if (r == 2)
            break;
      end
   endtask
   task test_done;
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial forever #2.5 clk = ~clk;
   initial
   begin
      repeat (60000) @(posedge clk);
      num_errors++;
      test_done;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      chk(sck_oe, 1'b0);
      for (int i = 0; i < 6; i++)
         rchk(3'(i), 8'h00);
      bus(1'b1, spi_pkg::IDX_CONTROL_A, 8'hff);
      rchk(spi_pkg::IDX_CONTROL_A, 8'h77);
      bus(1'b1, spi_pkg::IDX_CONTROL_B, 8'hff);
      rchk(spi_pkg::IDX_CONTROL_B, 8'hc7);
      bus(1'b1, spi_pkg::IDX_INT_EN, 8'hff);
      rchk(spi_pkg::IDX_INT_EN, 8'hf1);
      bus(1'b1, spi_pkg::IDX_CONTROL_B, 8'h02);
      chk(sck, 1'b1);
      rchk(spi_pkg::IDX_INT_EN, 8'h01);
      bus(1'b1, spi_pkg::IDX_CONTROL_B, 8'h00);
      bus(1'b1, spi_pkg::IDX_CONTROL_A, 8'h01);
      // Pin enables follow a control write by two edges
      repeat (2) @(posedge clk);
      chk({sck_oe, mosi_oe}, 2'b00);
      chk(sck, 1'b0);
      bus(1'b1, spi_pkg::IDX_CONTROL_A, 8'h21);
      bus(1'b1, spi_pkg::IDX_SHIFT_DATA, 8'ha5);
      bus(1'b1, spi_pkg::IDX_SHIFT_DATA, 8'h5a);
      wait_done;
      chk(q, 8'hc0);
      chk(irq, 1'b1);
      chk(got, 8'ha5);
      rchk(spi_pkg::IDX_SHIFT_DATA, 8'h3c);
      rchk(spi_pkg::IDX_INT_FLAGS, 8'h00);
      chk(irq, 1'b0);
      bus(1'b1, spi_pkg::IDX_CONTROL_A, 8'h61);
      bus(1'b1, spi_pkg::IDX_SHIFT_DATA, 8'h01);
      wait_done;
      chk(got, 8'h80);
      bus(1'b0, spi_pkg::IDX_SHIFT_DATA, 8'h00);
      for (int s = 0; s < 8; s++)
      begin
         bus(1'b1, spi_pkg::IDX_CONTROL_A, {2'b00, 1'b1, s[2], 1'b0, s[1:0], 1'b1});
         bus(1'b1, spi_pkg::IDX_SHIFT_DATA, 8'h00);
         period(n);
         chk(n, div[s % 4] >> (s / 4));
         wait_done;
         chk(q[7], 1'b1);
         bus(1'b0, spi_pkg::IDX_SHIFT_DATA, 8'h00);
      end
      bus(1'b1, spi_pkg::IDX_CONTROL_A, 8'h21);
      ss_in <= 1'b1;
      ss_n <= 1'b0;
      repeat (4) @(posedge clk);
      rchk(spi_pkg::IDX_CONTROL_A, 8'h01);
      rchk(spi_pkg::IDX_INT_FLAGS, 8'h80);
      chk(miso_oe, 1'b1);
      bus(1'b0, spi_pkg::IDX_SHIFT_DATA, 8'h00);
      ss_n <= 1'b1;
      bus(1'b1, spi_pkg::IDX_CONTROL_B, 8'h04);
      bus(1'b1, spi_pkg::IDX_CONTROL_A, 8'h21);
      ss_n <= 1'b0;
      repeat (4) @(posedge clk);
      rchk(spi_pkg::IDX_CONTROL_A, 8'h21);
      // Slowest divider, so an unaborted byte would finish inside the wait
      bus(1'b1, spi_pkg::IDX_CONTROL_A, 8'h27);
      bus(1'b1, spi_pkg::IDX_SHIFT_DATA, 8'h00);
      repeat (20) @(posedge clk);
      sleep <= 1'b1;
      repeat (4) @(posedge clk);
      sleep <= 1'b0;
      repeat (1200) @(posedge clk);
      rchk(spi_pkg::IDX_INT_FLAGS, 8'h00);
      chk(sck, 1'b0);
      ss_n <= 1'b1;
      bus(1'b1, spi_pkg::IDX_CONTROL_B, 8'h80);
      bus(1'b1, spi_pkg::IDX_CONTROL_A, 8'h21);
      bus(1'b1, spi_pkg::IDX_SHIFT_DATA, 8'h96);
      repeat (120) @(posedge clk);
      rchk(spi_pkg::IDX_INT_FLAGS, 8'he0);
      chk(irq, 1'b1);
      chk(got, 8'h96);
      rchk(spi_pkg::IDX_SHIFT_DATA, 8'h3c);
      bus(1'b1, spi_pkg::IDX_CONTROL_B, 8'hc0);
      bus(1'b1, spi_pkg::IDX_SHIFT_DATA, 8'h69);
      repeat (60) @(posedge clk);
      chk(got, 8'h69);
      test_done;
   end
endmodule
